// ===== hdl/fhbs_pkg.sv
// constants and carrier types of the flash command history and
// blank check status block.
// assumes a 32-bit byte address and 50 MHz single clock system.
package fhbs_pkg;

  // register byte addresses
  localparam logic [31:0] FHBS_CMD_HIST_ADDR = 32'hffa1_00a0;
  localparam logic [31:0] FHBS_ERR_SRC_ADDR  = 32'hffa1_00c0;
  localparam logic [31:0] FHBS_BC_DIR_ADDR   = 32'hffa1_00d0;
  localparam logic [31:0] FHBS_BC_RES_ADDR   = 32'hffa1_00d4;
  localparam logic [31:0] FHBS_FP_ADDR_ADDR  = 32'hffa1_00d8;
  localparam logic [31:0] FHBS_INIT_ADDR     = 32'hffa1_00ec;
  localparam logic [31:0] FHBS_IRQ_STAT_ADDR = 32'hffa1_00f0;
  localparam logic [31:0] FHBS_IRQ_MASK_ADDR = 32'hffa1_00f4;

  // access widths on the size port
  localparam logic [1:0] FHBS_SZ_8  = 2'h0;
  localparam logic [1:0] FHBS_SZ_16 = 2'h1;
  localparam logic [1:0] FHBS_SZ_32 = 2'h2;

  // values after reset
  localparam logic [15:0] FHBS_CMD_HIST_RST = 16'hffff;
  localparam logic [7:0]  FHBS_ERR_SRC_RST  = 8'h00;
  localparam logic        FHBS_BC_DIR_RST   = 1'b0;
  localparam logic        FHBS_BC_RES_RST   = 1'b0;
  localparam logic [18:0] FHBS_FP_OFS_RST   = 19'h0_0000;
  localparam logic [2:0]  FHBS_IRQ_RST      = 3'h0;

  // command codes
  localparam logic [7:0] FHBS_CODE_FINAL = 8'hd0;

  // error source encodings
  localparam logic [7:0] FHBS_ERR_NONE      = 8'h00;
  localparam logic [7:0] FHBS_ERR_PRG_LOCK  = 8'h01;
  localparam logic [7:0] FHBS_ERR_PRG_OTHER = 8'h02;
  localparam logic [7:0] FHBS_ERR_ERS_LOCK  = 8'h11;
  localparam logic [7:0] FHBS_ERR_ERS_OTHER = 8'h12;

  // field positions
  localparam int FHBS_DIR_BIT     = 0;
  localparam int FHBS_INIT_BIT    = 0;
  localparam int FHBS_IRQ_CMD_BIT = 0;
  localparam int FHBS_IRQ_ERR_BIT = 1;
  localparam int FHBS_IRQ_BC_BIT  = 2;
  localparam int FHBS_IRQ_W       = 3;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [1:0]  size;
  } fhbs_bus_t;

  typedef struct packed {
    logic       valid;
    logic       two_stage;
    logic [7:0] first_code;
    logic [7:0] code;
  } fhbs_cmd_t;

  typedef struct packed {
    logic valid;
    logic erase;
    logic lock_refused;
  } fhbs_err_t;

  typedef struct packed {
    logic        done;
    logic        written;
    logic [18:0] offset;
  } fhbs_bc_t;

endpackage

// ===== hdl/fhbs_top.sv
// command history, error source and blank check status registers
// of the flash sequencer, with a plain register port and interrupt.
// assumes the command engine pulses its events for one cycle and
// drives the ready and error flags from its own status register.
`timescale 1ns/1ns
`default_nettype none

module fhbs_top
  import fhbs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic [31:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic [1:0]  bus_size_i,
  output logic      [31:0] bus_rdata_o,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_two_stage_i,
  input  wire logic [7:0]  cmd_first_code_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic        err_valid_i,
  input  wire logic        err_erase_i,
  input  wire logic        err_lock_i,
  input  wire logic        ready_flag_i,
  input  wire logic        prg_err_flag_i,
  input  wire logic        ers_err_flag_i,
  input  wire logic        bc_done_i,
  input  wire logic        bc_written_i,
  input  wire logic [18:0] bc_offset_i,
  output logic             scan_dir_o,
  output logic             err_src_valid_o,
  output logic             fp_ofs_valid_o,
  output logic             irq_o
);

  fhbs_bus_t bus;
  fhbs_cmd_t cmd;
  fhbs_err_t err;
  fhbs_bc_t  bc;

  logic [7:0]          latest_r;
  logic [7:0]          prior_r;
  logic [7:0]          err_src_r;
  logic                dir_r;
  logic                res_r;
  logic [18:0]         ofs_r;
  logic [FHBS_IRQ_W-1:0] stat_r;
  logic [FHBS_IRQ_W-1:0] mask_r;
  logic [FHBS_IRQ_W-1:0] mask_nxt;
  logic [FHBS_IRQ_W-1:0] stat_nxt;
  logic [FHBS_IRQ_W-1:0] evt;
  logic [31:0]         rdata_nxt;
  logic [7:0]          err_code;
  logic                err_take;

  // gather ports into carriers
  assign bus = '{addr: bus_addr_i, wdata: bus_wdata_i, wr: bus_wr_i,
                 rd: bus_rd_i, size: bus_size_i};
  assign cmd = '{valid: cmd_valid_i, two_stage: cmd_two_stage_i,
                 first_code: cmd_first_code_i, code: cmd_code_i};
  assign err = '{valid: err_valid_i, erase: err_erase_i,
                 lock_refused: err_lock_i};
  assign bc  = '{done: bc_done_i, written: bc_written_i,
                 offset: bc_offset_i};

  // command history shift on each single-stage command; a two-stage one loads its first code and the final code
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latest_r <= FHBS_CMD_HIST_RST[15:8];
      prior_r  <= FHBS_CMD_HIST_RST[7:0];
    end else if (cmd.valid) begin
      if (cmd.two_stage) begin
        latest_r <= FHBS_CODE_FINAL;
        prior_r  <= cmd.first_code;
      end else begin
        latest_r <= cmd.code;
        prior_r  <= latest_r;
      end
    end
  end

  // error source encoding, lock refusal takes precedence
  always_comb begin
    err_code = FHBS_ERR_NONE;
    if (err.erase) begin
      err_code = err.lock_refused ? FHBS_ERR_ERS_LOCK
                                  : FHBS_ERR_ERS_OTHER;
    end else begin
      err_code = err.lock_refused ? FHBS_ERR_PRG_LOCK
                                  : FHBS_ERR_PRG_OTHER;
    end
  end

  // a report with both flags clear is dropped so the old source stays
  assign err_take = err.valid && (prg_err_flag_i || ers_err_flag_i);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_src_r <= FHBS_ERR_SRC_RST;
    end else if (err_take) begin
      err_src_r <= err_code;
    end
  end

  // blank check direction, init bit restores reset value
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_r <= FHBS_BC_DIR_RST;
    end else if (bus.wr && bus.addr == FHBS_INIT_ADDR &&
                 bus.size == FHBS_SZ_32 &&
                 bus.wdata[FHBS_INIT_BIT]) begin
      dir_r <= FHBS_BC_DIR_RST;
    end else if (bus.wr && bus.addr == FHBS_BC_DIR_ADDR &&
                 bus.size == FHBS_SZ_8) begin
      // only bit 0 is stored; upper bits are expected zero
      dir_r <= bus.wdata[FHBS_DIR_BIT];
    end
  end

  // result and offset land in one edge, ahead of the ready flag
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_r <= FHBS_BC_RES_RST;
      ofs_r <= FHBS_FP_OFS_RST;
    end else if (bc.done) begin
      res_r <= bc.written;
      if (bc.written) begin
        ofs_r <= bc.offset;
      end
    end
  end

  // interrupt events; set wins over a write-one clear
  assign evt[FHBS_IRQ_CMD_BIT] = cmd.valid;
  assign evt[FHBS_IRQ_ERR_BIT] = err_take;
  assign evt[FHBS_IRQ_BC_BIT]  = bc.done;

  always_comb begin
    stat_nxt = stat_r;
    if (bus.wr && bus.addr == FHBS_IRQ_STAT_ADDR &&
        bus.size == FHBS_SZ_32) begin
      stat_nxt = stat_r & ~bus.wdata[FHBS_IRQ_W-1:0];
    end
    stat_nxt = stat_nxt | evt;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_r <= FHBS_IRQ_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // next mask, so a mask write reaches irq in the same edge
  always_comb begin
    mask_nxt = mask_r;
    if (bus.wr && bus.addr == FHBS_IRQ_MASK_ADDR &&
        bus.size == FHBS_SZ_32) begin
      mask_nxt = bus.wdata[FHBS_IRQ_W-1:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_r <= FHBS_IRQ_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // irq follows next status and mask, never a cycle stale
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_nxt & mask_nxt);
    end
  end

  // read mux; wrong width or unmapped address answers zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (bus.addr)
      FHBS_CMD_HIST_ADDR: begin
        if (bus.size == FHBS_SZ_16) begin
          rdata_nxt[15:0] = {latest_r, prior_r};
        end
      end
      FHBS_ERR_SRC_ADDR: begin
        if (bus.size == FHBS_SZ_16) begin
          rdata_nxt[7:0] = err_src_r;
        end
      end
      FHBS_BC_DIR_ADDR: begin
        if (bus.size == FHBS_SZ_8) begin
          rdata_nxt[FHBS_DIR_BIT] = dir_r;
        end
      end
      FHBS_BC_RES_ADDR: begin
        if (bus.size == FHBS_SZ_8) begin
          rdata_nxt[0] = res_r;
        end
      end
      FHBS_FP_ADDR_ADDR: begin
        if (bus.size == FHBS_SZ_32) begin
          rdata_nxt[18:0] = ofs_r;
        end
      end
      FHBS_IRQ_STAT_ADDR: begin
        if (bus.size == FHBS_SZ_32) begin
          rdata_nxt[FHBS_IRQ_W-1:0] = stat_r;
        end
      end
      FHBS_IRQ_MASK_ADDR: begin
        if (bus.size == FHBS_SZ_32) begin
          rdata_nxt[FHBS_IRQ_W-1:0] = mask_r;
        end
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_rdata_o <= 32'h0000_0000;
    end else if (bus.rd) begin
      bus_rdata_o <= rdata_nxt;
    end else begin
      bus_rdata_o <= 32'h0000_0000;
    end
  end

  // direction out to the scan engine
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_dir_o <= FHBS_BC_DIR_RST;
    end else begin
      scan_dir_o <= dir_r;
    end
  end

  // validity qualifiers, registered so they lag inputs by one edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_src_valid_o <= 1'b0;
      fp_ofs_valid_o  <= 1'b0;
    end else begin
      err_src_valid_o <= ready_flag_i &&
                         (prg_err_flag_i || ers_err_flag_i);
      fp_ofs_valid_o  <= ready_flag_i && res_r;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  latest_load_a: assert property (
    cmd.valid && !cmd.two_stage |=> latest_r == $past(cmd.code))
    else $error("latest code not loaded");

  prior_shift_a: assert property (
    cmd.valid && !cmd.two_stage |=> prior_r == $past(latest_r))
    else $error("prior code not shifted");

  two_stage_a: assert property (
    cmd.valid && cmd.two_stage |=>
      latest_r == 8'hd0 && prior_r == $past(cmd.first_code))
    else $error("two-stage history wrong");

  history_hold_a: assert property (
    !cmd.valid |=> $stable(prior_r) && $stable(latest_r))
    else $error("history changed without command");

  err_hold_a: assert property (
    !prg_err_flag_i && !ers_err_flag_i |=> $stable(err_src_r))
    else $error("error source changed with flags clear");

  prg_code_a: assert property (
    err_take && !err.erase |=>
      err_src_r == ($past(err.lock_refused) ? 8'h01 : 8'h02))
    else $error("programming error code wrong");

  ers_code_a: assert property (
    err_take && err.erase |=>
      err_src_r == ($past(err.lock_refused) ? 8'h11 : 8'h12))
    else $error("erasure error code wrong");

  dir_init_a: assert property (
    bus.wr && bus.addr == FHBS_INIT_ADDR && bus.size == FHBS_SZ_32 &&
    bus.wdata[0] |=> !dir_r ##1 !scan_dir_o)
    else $error("init did not clear direction");

  dir_out_a: assert property (
    ##2 scan_dir_o == $past(dir_r))
    else $error("scan direction does not follow register");

  bc_record_a: assert property (
    bc.done && bc.written |=>
      res_r && ofs_r == $past(bc.offset))
    else $error("blank check result and offset not updated");

  bc_blank_a: assert property (
    bc.done && !bc.written |=> !res_r && $stable(ofs_r))
    else $error("blank result disturbed offset");

  fp_width_a: assert property (
    bus.rd && bus.addr == FHBS_FP_ADDR_ADDR && bus.size != FHBS_SZ_32
    |=> bus_rdata_o == 32'h0000_0000)
    else $error("narrow read of address register answered");

  dir_width_a: assert property (
    bus.wr && bus.addr == FHBS_BC_DIR_ADDR && bus.size != FHBS_SZ_8
    |=> $stable(dir_r))
    else $error("wide write changed direction");

  reserved_a: assert property (
    bus.rd && bus.addr == FHBS_BC_RES_ADDR
    |=> bus_rdata_o[31:1] == 31'h0)
    else $error("reserved result bits not zero");

  ofs_valid_a: assert property (
    fp_ofs_valid_o |-> $past(res_r) && $past(ready_flag_i))
    else $error("offset valid without result and ready");

  err_valid_a: assert property (
    ##1 err_src_valid_o == $past(ready_flag_i &&
        (prg_err_flag_i || ers_err_flag_i)))
    else $error("error source valid qualifier wrong");

  irq_level_a: assert property (
    irq_o == |(stat_r & mask_r))
    else $error("interrupt level does not follow status");

  stat_set_a: assert property (
    |evt |=> (stat_r & $past(evt)) == $past(evt))
    else $error("status event lost to a clear");

  two_stage_c: cover property (cmd.valid && cmd.two_stage ##1 cmd.valid);
  err_lock_c: cover property (err_take && err.lock_refused);
  bc_found_c: cover property (bc.done && bc.written && dir_r);
  irq_c: cover property (irq_o ##1 !irq_o);

endmodule // fhbs_top

`default_nettype wire

// ===== tb/fhbs_tb.sv
// self-checking bench for the command history, error source and
// blank check status block; drives every port itself, no partner.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import fhbs_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [31:0] bus_addr_i = '0;
  logic [31:0] bus_wdata_i = '0;
  logic        bus_wr_i = 1'b0;
  logic        bus_rd_i = 1'b0;
  logic [1:0]  bus_size_i = '0;
  logic [31:0] bus_rdata_o;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_two_stage_i = 1'b0;
  logic [7:0]  cmd_first_code_i = '0;
  logic [7:0]  cmd_code_i = '0;
  logic        err_valid_i = 1'b0;
  logic        err_erase_i = 1'b0;
  logic        err_lock_i = 1'b0;
  logic        ready_flag_i = 1'b1;
  logic        prg_err_flag_i = 1'b0;
  logic        ers_err_flag_i = 1'b0;
  logic        bc_done_i = 1'b0;
  logic        bc_written_i = 1'b0;
  logic [18:0] bc_offset_i = '0;
  logic        scan_dir_o;
  logic        err_src_valid_o;
  logic        fp_ofs_valid_o;
  logic        irq_o;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [15:0] hist = 16'hffff;
  logic [7:0]  sc [8] = '{8'he8, 8'hea, 8'hb0, 8'hd0,
                          8'h50, 8'hb3, 8'h40, 8'h45};
  logic [7:0]  fc [3] = '{8'h20, 8'h71, 8'h77};
  logic [7:0]  ec [4] = '{8'h01, 8'h02, 8'h11, 8'h12};

  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;

  fhbs_top i_dut (
    .clk_sys_i        (clk_sys_i),
    .arst_n_i         (arst_n_i),
    .bus_addr_i       (bus_addr_i),
    .bus_wdata_i      (bus_wdata_i),
    .bus_wr_i         (bus_wr_i),
    .bus_rd_i         (bus_rd_i),
    .bus_size_i       (bus_size_i),
    .bus_rdata_o      (bus_rdata_o),
    .cmd_valid_i      (cmd_valid_i),
    .cmd_two_stage_i  (cmd_two_stage_i),
    .cmd_first_code_i (cmd_first_code_i),
    .cmd_code_i       (cmd_code_i),
    .err_valid_i      (err_valid_i),
    .err_erase_i      (err_erase_i),
    .err_lock_i       (err_lock_i),
    .ready_flag_i     (ready_flag_i),
    .prg_err_flag_i   (prg_err_flag_i),
    .ers_err_flag_i   (ers_err_flag_i),
    .bc_done_i        (bc_done_i),
    .bc_written_i     (bc_written_i),
    .bc_offset_i      (bc_offset_i),
    .scan_dir_o       (scan_dir_o),
    .err_src_valid_o  (err_src_valid_o),
    .fp_ofs_valid_o   (fp_ofs_valid_o),
    .irq_o            (irq_o)
  );

  // case equality so an unknown never counts as a match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] s);
    @(posedge clk_sys_i);
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    bus_size_i  <= s;
    bus_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    bus_wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [1:0] s,
                        input logic [31:0] e);
    @(posedge clk_sys_i);
    bus_addr_i <= a;
    bus_size_i <= s;
    bus_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    bus_rd_i   <= 1'b0;
    #1;
    chk(bus_rdata_o, e);
  endtask

  task automatic cmd(input logic two, input logic [7:0] f, c);
    @(posedge clk_sys_i);
    cmd_valid_i      <= 1'b1;
    cmd_two_stage_i  <= two;
    cmd_first_code_i <= f;
    cmd_code_i       <= c;
    @(posedge clk_sys_i);
    cmd_valid_i      <= 1'b0;
    hist = two ? {FHBS_CODE_FINAL, f} : {c, hist[15:8]};
  endtask

  // flags are levels that must stand with the report pulse
  task automatic err(input logic ers, lck, pf, ef);
    @(posedge clk_sys_i);
    prg_err_flag_i <= pf;
    ers_err_flag_i <= ef;
    err_erase_i    <= ers;
    err_lock_i     <= lck;
    err_valid_i    <= 1'b1;
    @(posedge clk_sys_i);
    err_valid_i    <= 1'b0;
  endtask

  task automatic bc(input logic w, input logic [18:0] o);
    @(posedge clk_sys_i);
    bc_written_i <= w;
    bc_offset_i  <= o;
    bc_done_i    <= 1'b1;
    @(posedge clk_sys_i);
    bc_done_i    <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // run takes about 150 cycles; this is far beyond it
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    // values after reset, unmapped place reads zero
    rd_chk(FHBS_CMD_HIST_ADDR, FHBS_SZ_16, 32'h0000_ffff);
    // read data fall back to zero once their cycle is over
    @(posedge clk_sys_i);
    #1;
    chk(bus_rdata_o, 32'h0000_0000);
    rd_chk(FHBS_ERR_SRC_ADDR, FHBS_SZ_16, 32'h0000_0000);
    rd_chk(FHBS_BC_DIR_ADDR, FHBS_SZ_8, 32'h0000_0000);
    rd_chk(FHBS_BC_RES_ADDR, FHBS_SZ_8, 32'h0000_0000);
    rd_chk(FHBS_FP_ADDR_ADDR, FHBS_SZ_32, 32'h0000_0000);
    rd_chk(FHBS_IRQ_STAT_ADDR, FHBS_SZ_32, 32'h0000_0000);
    rd_chk(32'hffa1_00a4, FHBS_SZ_32, 32'h0000_0000);
    $display("test reset values done");

    // history: every single code, then every two-stage code
    wr(FHBS_IRQ_MASK_ADDR, 32'h0000_0007, FHBS_SZ_32);
    foreach (sc[i]) begin
      cmd(1'b0, 8'h00, sc[i]);
      rd_chk(FHBS_CMD_HIST_ADDR, FHBS_SZ_16, {16'h0, hist});
    end
    foreach (fc[i]) begin
      cmd(1'b1, fc[i], 8'h00);
      rd_chk(FHBS_CMD_HIST_ADDR, FHBS_SZ_16, {16'h0, hist});
    end
    // back to back commands, history not writable
    @(posedge clk_sys_i);
    cmd_valid_i     <= 1'b1;
    cmd_two_stage_i <= 1'b0;
    cmd_code_i      <= 8'he8;
    cmd(1'b0, 8'h00, 8'hea);
    wr(FHBS_CMD_HIST_ADDR, 32'h0000_1234, FHBS_SZ_16);
    rd_chk(FHBS_CMD_HIST_ADDR, FHBS_SZ_16, 32'h0000_eae8);
    chk(32'(irq_o), 32'h1);
    wr(FHBS_IRQ_STAT_ADDR, 32'h0000_0001, FHBS_SZ_32);
    #1;
    chk(32'(irq_o), 32'h0);
    $display("test command history done");

    // all four error codes, then a report with no flag is ignored
    foreach (ec[i]) begin
      err(ec[i][4], ~ec[i][1], ~ec[i][4], ec[i][4]);
      rd_chk(FHBS_ERR_SRC_ADDR, FHBS_SZ_16, {24'h0, ec[i]});
      chk(32'(err_src_valid_o), 32'h1);
    end
    // error flag still set, but sequencer busy: source not valid
    @(posedge clk_sys_i);
    ready_flag_i <= 1'b0;
    @(posedge clk_sys_i);
    ready_flag_i <= 1'b1;
    #1;
    chk(32'(err_src_valid_o), 32'h0);
    err(1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(FHBS_ERR_SRC_ADDR, FHBS_SZ_16, 32'h0000_0012);
    chk(32'(err_src_valid_o), 32'h0);
    rd_chk(FHBS_IRQ_STAT_ADDR, FHBS_SZ_32, 32'h0000_0002);
    wr(FHBS_IRQ_STAT_ADDR, 32'h0000_0002, FHBS_SZ_32);
    $display("test error source done");

    // direction set, wrong width dropped, init bit restores
    wr(FHBS_BC_DIR_ADDR, 32'h0000_0001, FHBS_SZ_8);
    rd_chk(FHBS_BC_DIR_ADDR, FHBS_SZ_8, 32'h0000_0001);
    chk(32'(scan_dir_o), 32'h1);
    wr(FHBS_BC_DIR_ADDR, 32'h0000_0000, FHBS_SZ_32);
    rd_chk(FHBS_BC_DIR_ADDR, FHBS_SZ_8, 32'h0000_0001);
    rd_chk(FHBS_BC_DIR_ADDR, FHBS_SZ_16, 32'h0000_0000);
    wr(FHBS_INIT_ADDR, 32'h0000_0001, FHBS_SZ_32);
    rd_chk(FHBS_BC_DIR_ADDR, FHBS_SZ_8, 32'h0000_0000);
    chk(32'(scan_dir_o), 32'h0);
    $display("test scan direction done");

    // written area records offset; erased one keeps it
    wr(FHBS_IRQ_MASK_ADDR, 32'h0000_0003, FHBS_SZ_32);
    // downward scan while the check runs
    wr(FHBS_BC_DIR_ADDR, 32'h0000_0001, FHBS_SZ_8);
    bc(1'b1, 19'h5_a5a5);
    #1;
    chk(32'(irq_o), 32'h0);
    rd_chk(FHBS_BC_RES_ADDR, FHBS_SZ_8, 32'h0000_0001);
    rd_chk(FHBS_FP_ADDR_ADDR, FHBS_SZ_32, 32'h0005_a5a5);
    chk(32'(fp_ofs_valid_o), 32'h1);
    // result still set, but sequencer busy: offset not valid
    @(posedge clk_sys_i);
    ready_flag_i <= 1'b0;
    @(posedge clk_sys_i);
    ready_flag_i <= 1'b1;
    #1;
    chk(32'(fp_ofs_valid_o), 32'h0);
    rd_chk(FHBS_FP_ADDR_ADDR, FHBS_SZ_16, 32'h0000_0000);
    bc(1'b0, 19'h1_2345);
    rd_chk(FHBS_BC_RES_ADDR, FHBS_SZ_8, 32'h0000_0000);
    rd_chk(FHBS_FP_ADDR_ADDR, FHBS_SZ_32, 32'h0005_a5a5);
    chk(32'(fp_ofs_valid_o), 32'h0);
    wr(FHBS_IRQ_MASK_ADDR, 32'h0000_0007, FHBS_SZ_32);
    #1;
    chk(32'(irq_o), 32'h1);
    wr(FHBS_IRQ_STAT_ADDR, 32'h0000_0004, FHBS_SZ_32);
    rd_chk(FHBS_IRQ_STAT_ADDR, FHBS_SZ_32, 32'h0000_0000);
    chk(32'(irq_o), 32'h0);
    $display("test blank check done");
    end_of_test();
  end

endmodule // testbench

`default_nettype wire
